//--- shared/pmcs_pkg.sv
// Constants, types and decode helpers for the power mode and clock select block
package pmcs_pkg;

  // Register offsets on the special function register port
  localparam logic [7:0] PMCS_ADDR_POWER_MODE_CONTROL = 8'h87;
  localparam logic [7:0] PMCS_ADDR_SYSTEM_CLOCK_SELECT = 8'h8F;
  localparam logic [7:0] PMCS_ADDR_WAKE_SOURCE_MASK = 8'h9F;
  localparam logic [7:0] PMCS_ADDR_CLOCK_DIVIDER_MODE = 8'hC4;

  // Reset values
  localparam logic [7:0] PMCS_RST_POWER_MODE_CONTROL = 8'h00;
  localparam logic [7:0] PMCS_RST_SYSTEM_CLOCK_SELECT = 8'h0C;
  localparam logic [7:0] PMCS_RST_WAKE_SOURCE_MASK = 8'hFF;
  localparam logic [7:0] PMCS_RST_CLOCK_DIVIDER_MODE = 8'h40;
  // Pre-divider code after reset, divide by 32; the reset byte above holds the other fields
  localparam logic [3:0] PMCS_RST_FAST_OSC_PREDIV = 4'h9;

  // power_mode_control fields
  localparam int PMCS_PMC_BAUD_DOUBLER_BIT = 7;
  localparam int PMCS_PMC_SLEEP_BIT = 2;
  localparam int PMCS_PMC_STOP_BIT = 1;
  localparam int PMCS_PMC_IDLE_BIT = 0;

  // clock_divider_mode fields
  localparam int PMCS_CDM_DIVIDER_UPPER_BIT = 7;
  localparam int PMCS_CDM_DIVIDER_LOWER_BIT = 6;
  localparam int PMCS_CDM_AUTO_RETURN_BIT = 5;

  // system_clock_select fields
  localparam int PMCS_CKS_PREDIV_LSB = 4;
  localparam int PMCS_CKS_REGULATOR_READY_DELAY_LSB = 2;
  localparam int PMCS_CKS_SOURCE_LSB = 0;

  // Clock source codes
  localparam logic [1:0] PMCS_SRC_FAST_DIV = 2'h0;
  localparam logic [1:0] PMCS_SRC_SLOW_32K = 2'h1;
  localparam logic [1:0] PMCS_SRC_FAST_DIV_ALT = 2'h2;
  localparam logic [1:0] PMCS_SRC_EXTERNAL = 2'h3;

  // Regulator ready delays in slow oscillator cycles
  localparam logic [8:0] PMCS_REGULATOR_READY_DELAY_CYC_0 = 9'h008;
  localparam logic [8:0] PMCS_REGULATOR_READY_DELAY_CYC_1 = 9'h010;
  localparam logic [8:0] PMCS_REGULATOR_READY_DELAY_CYC_2 = 9'h040;
  localparam logic [8:0] PMCS_REGULATOR_READY_DELAY_CYC_3 = 9'h100;

  // Fast oscillator restart budget after a wake, in fast oscillator cycles
  localparam int PMCS_SLEEP_WAKE_LIMIT_CYC = 64;
  localparam int PMCS_OSC_SETTLE_CYC = 16;

  localparam int PMCS_WAKE_LINES = 8;

  typedef enum logic [2:0] {
    PMCS_ST_REG_WAIT,
    PMCS_ST_OSC_WAIT,
    PMCS_ST_RUN,
    PMCS_ST_IDLE,
    PMCS_ST_STOP,
    PMCS_ST_SLEEP
  } pmcs_state_type;

  typedef struct packed {
    logic cpu_clk_en;
    logic integ_clk_en;
    logic integ_rst;
    logic ext_periph_clk_en;
    logic fast_osc_en;
    logic main_reg_en;
    logic bandgap_en;
  } pmcs_gate_type;

  typedef struct packed {
    logic [1:0] source;
    logic [8:0] prediv_ratio;
    logic full_speed;
    logic auto_return;
    logic baud_double;
  } pmcs_clk_cfg_type;

  // Divisor for the fast oscillator pre-divider; 1 means undivided
  function automatic logic [8:0] pmcs_prediv_ratio(input logic [3:0] code);
    logic [8:0] r;
    r = 9'h100;
    if (code == 4'h0)
      r = 9'h001;
    else if (code <= 4'h8)
      r = {4'h0, code, 1'b0};
    else if (code == 4'h9)
      r = 9'h020;
    else if (code == 4'hA)
      r = 9'h040;
    else if (code == 4'hB)
      r = 9'h080;
    return r;
  endfunction

  function automatic logic [8:0] pmcs_regulator_ready_delay_cycles(input logic [1:0] code);
    logic [8:0] r;
    r = PMCS_REGULATOR_READY_DELAY_CYC_3;
    case (code)
      2'h0: r = PMCS_REGULATOR_READY_DELAY_CYC_0;
      2'h1: r = PMCS_REGULATOR_READY_DELAY_CYC_1;
      2'h2: r = PMCS_REGULATOR_READY_DELAY_CYC_2;
      default: r = PMCS_REGULATOR_READY_DELAY_CYC_3;
    endcase
    return r;
  endfunction

endpackage

//--- hw/pmcs_edge.sv
// Rising edge detector for the wake source lines
`timescale 1ns/1ps
module pmcs_edge
  import pmcs_pkg::*;
#(
  parameter int WIDTH = 8
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise
);

  typedef struct packed {
    logic [WIDTH-1:0] prev;
  } pmcs_edge_state_type;

  pmcs_edge_state_type q_ff;
  pmcs_edge_state_type nxt_q;

  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.prev = level;
  end

  // Edge only, so a source held active cannot keep re-waking the part
  assign rise = level & ~q_ff.prev;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q_ff <= '{prev: '0};
    else
      q_ff <= nxt_q;
  end

endmodule

//--- hw/pmcs_top.sv
// Power mode sequencer and system clock selection registers
// How it works
// (RULE1) Sleep plus stop bits gate all clocks
// (RULE2) Sleep exits on wake/reset, clears both bits
// (RULE3) Sleep turns off band gap and regulator
// (RULE4) Sleep wake completes within 64 oscillator cycles
// (RULE5) Stop alone gates CPU and peripheral clocks
// (RULE6) Stop exits on wake/reset, clears stop bit
// (RULE7) Idle stops and resets CPU-side peripherals
// (RULE8) Idle exits on enabled interrupt or reset
// (RULE9) Hardware clears idle bit on exit
// (RULE10) Idle exit restarts clock, vectors at once
// (RULE11) Upper divider bit reads zero, ignores writes
// (RULE12) Pre-divider code maps to fast oscillator divisor
// (RULE13) Regulator wait of 8/16/64/256 slow cycles
// (RULE14) Source field picks fast, slow or external
// (RULE15) Clock select and mask writes need window
// (RULE16) Eight mask bits enable wake sources
// (RULE17) Wake always triggered by source edge
// (RULE18) Disabled waking interrupt resumes without vector
// (RULE19) Oscillator restarts before system clock resumes
// (RULE20) Only non-clocked sources wake stop/sleep
// (RULE21) Software opens timed window with AA, 55
// (RULE22) Stop exit keeps prior clock settings
// (RULE23) Entry waits for writing instruction to finish
`timescale 1ns/1ps
module pmcs_top
  import pmcs_pkg::*;
#(
  parameter int OSC_SETTLE_CYC = PMCS_OSC_SETTLE_CYC,
  parameter int WAKE_LINES = PMCS_WAKE_LINES
)
(
  input wire logic CLK_SYS,
  input wire logic RESET_PIN_LOW,
  input wire logic [7:0] SFR_ADDR,
  input wire logic SFR_WR,
  input wire logic [7:0] SFR_WDATA,
  input wire logic CPU_INSTR_DONE,
  input wire logic TIMED_WINDOW_OPEN,
  input wire logic SLOW_OSC_TICK,
  input wire logic [WAKE_LINES-1:0] WAKE_SRC,
  input wire logic [WAKE_LINES-1:0] WAKE_IRQ_EN,
  input wire logic IDLE_WAKE_IRQ,
  output logic [7:0] SFR_RDATA,
  output pmcs_gate_type GATE,
  output pmcs_clk_cfg_type CLK_CFG,
  output pmcs_state_type MODE,
  output logic WAKE_VECTOR,
  output logic WAKE_RESUME
);

  localparam logic [7:0] OSC_SETTLE_LAST = 8'(OSC_SETTLE_CYC - 1);

  typedef struct packed {
    pmcs_state_type state;
    logic baud_doubler_bit;
    logic sleep_bit;
    logic stop_bit;
    logic idle_bit;
    logic divider_lower_bit;
    logic auto_return_bit;
    logic [3:0] fast_osc_prediv;
    logic [1:0] regulator_ready_delay;
    logic [1:0] source_select_field;
    logic [WAKE_LINES-1:0] wake_source_mask;
    logic [8:0] reg_cnt;
    logic [7:0] osc_cnt;
    logic from_sleep;
    logic vector_pending;
    logic [7:0] rdata;
    pmcs_gate_type gate;
    pmcs_clk_cfg_type cfg;
    logic wake_vector;
    logic wake_resume;
  } pmcs_top_state_type;

  pmcs_top_state_type q_ff;
  pmcs_top_state_type nxt_q;
  logic [WAKE_LINES-1:0] wake_rise;
  logic [WAKE_LINES-1:0] wake_hit;
  logic wr_pmc;
  logic wr_cks;
  logic wr_wkm;
  logic wr_cdm;

  pmcs_edge #(
    .WIDTH(WAKE_LINES)
  ) u_wake_edge (
    .clk(CLK_SYS),
    .rst_n(RESET_PIN_LOW),
    .level(WAKE_SRC),
    .rise(wake_rise)
  );

  // Only the pin-side wake lines are looked at; clocked peripherals have no path here
  assign wake_hit = wake_rise & q_ff.wake_source_mask; // (RULE16) (RULE17) (RULE20)

  always_comb
  begin
    wr_pmc = 1'b0;
    wr_cks = 1'b0;
    wr_wkm = 1'b0;
    wr_cdm = 1'b0;
    if (SFR_WR && SFR_ADDR == PMCS_ADDR_POWER_MODE_CONTROL)
      wr_pmc = 1'b1;
    else if (SFR_WR && SFR_ADDR == PMCS_ADDR_SYSTEM_CLOCK_SELECT)
      wr_cks = TIMED_WINDOW_OPEN; // (RULE15) (RULE21)
    else if (SFR_WR && SFR_ADDR == PMCS_ADDR_WAKE_SOURCE_MASK)
      wr_wkm = TIMED_WINDOW_OPEN; // (RULE15)
    else if (SFR_WR && SFR_ADDR == PMCS_ADDR_CLOCK_DIVIDER_MODE)
      wr_cdm = 1'b1;
  end

  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.wake_vector = 1'b0;
    nxt_q.wake_resume = 1'b0;

    // Register writes; the CPU is stopped in any low power state, so no write races a clear
    if (wr_pmc)
    begin
      nxt_q.baud_doubler_bit = SFR_WDATA[PMCS_PMC_BAUD_DOUBLER_BIT];
      nxt_q.sleep_bit = SFR_WDATA[PMCS_PMC_SLEEP_BIT];
      nxt_q.stop_bit = SFR_WDATA[PMCS_PMC_STOP_BIT];
      nxt_q.idle_bit = SFR_WDATA[PMCS_PMC_IDLE_BIT];
    end
    if (wr_cdm)
    begin
      nxt_q.divider_lower_bit = SFR_WDATA[PMCS_CDM_DIVIDER_LOWER_BIT];
      nxt_q.auto_return_bit = SFR_WDATA[PMCS_CDM_AUTO_RETURN_BIT];
    end
    if (wr_cks)
    begin
      nxt_q.fast_osc_prediv = SFR_WDATA[PMCS_CKS_PREDIV_LSB +: 4];
      nxt_q.regulator_ready_delay = SFR_WDATA[PMCS_CKS_REGULATOR_READY_DELAY_LSB +: 2];
      nxt_q.source_select_field = SFR_WDATA[PMCS_CKS_SOURCE_LSB +: 2];
    end
    if (wr_wkm)
      nxt_q.wake_source_mask = SFR_WDATA[WAKE_LINES-1:0];

    case (q_ff.state)
      PMCS_ST_REG_WAIT:
      begin
        // Regulator settles on the slow oscillator, after reset or a sleep wake
        if (SLOW_OSC_TICK)
          nxt_q.reg_cnt = q_ff.reg_cnt + 9'h001;
        if (SLOW_OSC_TICK && q_ff.reg_cnt + 9'h001 >= pmcs_regulator_ready_delay_cycles(q_ff.regulator_ready_delay)) // (RULE13)
        begin
          nxt_q.reg_cnt = 9'h000;
          nxt_q.osc_cnt = 8'h00;
          nxt_q.state = PMCS_ST_OSC_WAIT;
        end
      end
      PMCS_ST_OSC_WAIT:
      begin
        // Oscillator is already enabled here; system clock held off until it settles
        nxt_q.osc_cnt = q_ff.osc_cnt + 8'h01; // (RULE19) (RULE4)
        if (q_ff.osc_cnt >= OSC_SETTLE_LAST)
        begin
          nxt_q.osc_cnt = 8'h00;
          nxt_q.state = PMCS_ST_RUN;
          if (q_ff.from_sleep)
            nxt_q.sleep_bit = 1'b0; // (RULE2)
          nxt_q.stop_bit = 1'b0; // (RULE2) (RULE6)
          nxt_q.from_sleep = 1'b0;
          nxt_q.wake_vector = q_ff.vector_pending; // (RULE18)
          nxt_q.wake_resume = ~q_ff.vector_pending; // (RULE18)
          nxt_q.vector_pending = 1'b0;
        end
      end
      PMCS_ST_RUN:
      begin
        // Entry waits for the instruction that wrote the mode bits to retire
        if (CPU_INSTR_DONE && !wr_pmc) // (RULE23)
        begin
          if (q_ff.stop_bit && q_ff.sleep_bit)
            nxt_q.state = PMCS_ST_SLEEP; // (RULE1)
          else if (q_ff.stop_bit)
            nxt_q.state = PMCS_ST_STOP; // (RULE5)
          else if (q_ff.idle_bit)
            nxt_q.state = PMCS_ST_IDLE; // (RULE7)
        end
      end
      PMCS_ST_IDLE:
      begin
        if (IDLE_WAKE_IRQ) // (RULE8)
        begin
          nxt_q.state = PMCS_ST_RUN;
          nxt_q.idle_bit = 1'b0; // (RULE9)
          nxt_q.wake_vector = 1'b1; // (RULE10)
        end
      end
      PMCS_ST_STOP:
      begin
        if (|wake_hit) // (RULE6) (RULE20)
        begin
          nxt_q.state = PMCS_ST_OSC_WAIT;
          nxt_q.osc_cnt = 8'h00;
          nxt_q.from_sleep = 1'b0;
          nxt_q.vector_pending = |(wake_hit & WAKE_IRQ_EN); // (RULE18)
        end
      end
      PMCS_ST_SLEEP:
      begin
        if (|wake_hit) // (RULE2) (RULE20)
        begin
          nxt_q.state = PMCS_ST_REG_WAIT;
          nxt_q.reg_cnt = 9'h000;
          nxt_q.from_sleep = 1'b1;
          nxt_q.vector_pending = |(wake_hit & WAKE_IRQ_EN); // (RULE18)
        end
      end
      default:
      begin
        nxt_q.state = PMCS_ST_RUN;
      end
    endcase

    // Gates follow the next state so every output leaves a flip-flop
    nxt_q.gate.cpu_clk_en = (nxt_q.state == PMCS_ST_RUN);
    nxt_q.gate.integ_clk_en = (nxt_q.state == PMCS_ST_RUN); // (RULE7)
    nxt_q.gate.integ_rst = (nxt_q.state == PMCS_ST_IDLE); // (RULE7)
    nxt_q.gate.ext_periph_clk_en = (nxt_q.state == PMCS_ST_RUN) || (nxt_q.state == PMCS_ST_IDLE); // (RULE7)
    nxt_q.gate.fast_osc_en = (nxt_q.state == PMCS_ST_RUN) || (nxt_q.state == PMCS_ST_IDLE)
                             || (nxt_q.state == PMCS_ST_OSC_WAIT); // (RULE19)
    nxt_q.gate.main_reg_en = (nxt_q.state != PMCS_ST_SLEEP); // (RULE3)
    nxt_q.gate.bandgap_en = (nxt_q.state != PMCS_ST_SLEEP); // (RULE3)

    // Settings registers are untouched by low power entry, so a wake resumes them
    nxt_q.cfg.source = nxt_q.source_select_field; // (RULE14) (RULE22)
    nxt_q.cfg.prediv_ratio = pmcs_prediv_ratio(nxt_q.fast_osc_prediv); // (RULE12)
    nxt_q.cfg.full_speed = nxt_q.divider_lower_bit; // (RULE11)
    nxt_q.cfg.auto_return = nxt_q.auto_return_bit;
    nxt_q.cfg.baud_double = nxt_q.baud_doubler_bit;

    // Read data: one cycle after the address, unmapped reads return zero
    nxt_q.rdata = 8'h00;
    if (SFR_ADDR == PMCS_ADDR_POWER_MODE_CONTROL)
      nxt_q.rdata[PMCS_PMC_BAUD_DOUBLER_BIT] = q_ff.baud_doubler_bit;
    else if (SFR_ADDR == PMCS_ADDR_SYSTEM_CLOCK_SELECT)
    begin
      nxt_q.rdata[PMCS_CKS_PREDIV_LSB +: 4] = q_ff.fast_osc_prediv;
      nxt_q.rdata[PMCS_CKS_SOURCE_LSB +: 2] = q_ff.source_select_field;
    end
    else if (SFR_ADDR == PMCS_ADDR_WAKE_SOURCE_MASK)
      nxt_q.rdata[WAKE_LINES-1:0] = q_ff.wake_source_mask;
    else if (SFR_ADDR == PMCS_ADDR_CLOCK_DIVIDER_MODE)
    begin
      nxt_q.rdata[PMCS_CDM_DIVIDER_UPPER_BIT] = 1'b0; // (RULE11)
      nxt_q.rdata[PMCS_CDM_DIVIDER_LOWER_BIT] = q_ff.divider_lower_bit;
      nxt_q.rdata[PMCS_CDM_AUTO_RETURN_BIT] = q_ff.auto_return_bit;
    end
  end

  always_ff @(posedge CLK_SYS or negedge RESET_PIN_LOW)
  begin
    if (!RESET_PIN_LOW)
    begin
      // Reset starts with the regulator wait, like a sleep wake
      q_ff.state <= PMCS_ST_REG_WAIT;
      q_ff.baud_doubler_bit <= PMCS_RST_POWER_MODE_CONTROL[PMCS_PMC_BAUD_DOUBLER_BIT];
      q_ff.sleep_bit <= PMCS_RST_POWER_MODE_CONTROL[PMCS_PMC_SLEEP_BIT];
      q_ff.stop_bit <= PMCS_RST_POWER_MODE_CONTROL[PMCS_PMC_STOP_BIT];
      q_ff.idle_bit <= PMCS_RST_POWER_MODE_CONTROL[PMCS_PMC_IDLE_BIT];
      q_ff.divider_lower_bit <= PMCS_RST_CLOCK_DIVIDER_MODE[PMCS_CDM_DIVIDER_LOWER_BIT];
      q_ff.auto_return_bit <= PMCS_RST_CLOCK_DIVIDER_MODE[PMCS_CDM_AUTO_RETURN_BIT];
      q_ff.fast_osc_prediv <= PMCS_RST_FAST_OSC_PREDIV; // (RULE12)
      q_ff.regulator_ready_delay <= 2'h3;
      q_ff.source_select_field <= PMCS_RST_SYSTEM_CLOCK_SELECT[PMCS_CKS_SOURCE_LSB +: 2];
      q_ff.wake_source_mask <= PMCS_RST_WAKE_SOURCE_MASK[WAKE_LINES-1:0];
      q_ff.reg_cnt <= 9'h000;
      q_ff.osc_cnt <= 8'h00;
      q_ff.from_sleep <= 1'b0;
      q_ff.vector_pending <= 1'b0;
      q_ff.rdata <= 8'h00;
      q_ff.gate <= '{cpu_clk_en: 1'b0, integ_clk_en: 1'b0, integ_rst: 1'b0, ext_periph_clk_en: 1'b0,
                     fast_osc_en: 1'b0, main_reg_en: 1'b1, bandgap_en: 1'b1};
      q_ff.cfg <= '{source: 2'h0, prediv_ratio: 9'h020, full_speed: 1'b1, auto_return: 1'b0,
                    baud_double: 1'b0};
      q_ff.wake_vector <= 1'b0;
      q_ff.wake_resume <= 1'b0;
    end
    else
      q_ff <= nxt_q;
  end

  assign SFR_RDATA = q_ff.rdata;
  assign GATE = q_ff.gate;
  assign CLK_CFG = q_ff.cfg;
  assign MODE = q_ff.state;
  assign WAKE_VECTOR = q_ff.wake_vector;
  assign WAKE_RESUME = q_ff.wake_resume;

endmodule

//--- test/pmcs_osc_model.sv
// Slow oscillator model giving one tick per period
`timescale 1ns/1ps
module pmcs_osc_model
#(
  parameter int DIV = 4
)
(
  input wire logic clk,
  input wire logic rst_n,
  output logic tick
);
  int cnt;
  // Free running, so tick phase versus a wake event is arbitrary
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      cnt <= 0;
      tick <= 1'b0;
    end
    else
    begin
      cnt <= (cnt == DIV - 1) ? 0 : cnt + 1;
      tick <= (cnt == DIV - 1);
    end
endmodule

//--- test/pmcs_top_asserts.sv
// Port level checker for the power mode and clock select block
`timescale 1ns/1ps
module pmcs_top_asserts
  import pmcs_pkg::*;
#(
  parameter int OSC_SETTLE_CYC = PMCS_OSC_SETTLE_CYC,
  parameter int WAKE_LINES = PMCS_WAKE_LINES
)
(
  input wire logic CLK_SYS,
  input wire logic RESET_PIN_LOW,
  input wire logic [7:0] SFR_ADDR,
  input wire logic CPU_INSTR_DONE,
  input wire logic IDLE_WAKE_IRQ,
  input wire logic [7:0] SFR_RDATA,
  input wire pmcs_gate_type GATE,
  input wire pmcs_state_type MODE,
  input wire logic WAKE_VECTOR,
  input wire logic WAKE_RESUME
);
  logic [8:0] osc_cnt_ff;
  logic [8:0] nxt_osc_cnt;
  // Length of the last oscillator restart, held into the first run cycle
  always_comb nxt_osc_cnt = (MODE == PMCS_ST_OSC_WAIT) ? osc_cnt_ff + 9'h001 : 9'h000;
  always_ff @(posedge CLK_SYS or negedge RESET_PIN_LOW)
    if (!RESET_PIN_LOW)
      osc_cnt_ff <= 9'h000;
    else
      osc_cnt_ff <= nxt_osc_cnt;

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_PIN_LOW);

  sequence s_idle_wake;
    MODE == PMCS_ST_IDLE && IDLE_WAKE_IRQ;
  endsequence
  sequence s_vector_run;
    MODE == PMCS_ST_RUN && WAKE_VECTOR && !WAKE_RESUME;
  endsequence

  property p_sleep_off;
    MODE == PMCS_ST_SLEEP |-> !GATE.main_reg_en && !GATE.bandgap_en && !GATE.cpu_clk_en && !GATE.ext_periph_clk_en;
  endproperty
  property p_stop_off;
    MODE == PMCS_ST_STOP |-> !GATE.cpu_clk_en && !GATE.integ_clk_en && !GATE.ext_periph_clk_en && !GATE.fast_osc_en;
  endproperty
  property p_idle_gate;
    MODE == PMCS_ST_IDLE |-> !GATE.cpu_clk_en && !GATE.integ_clk_en && GATE.integ_rst && GATE.ext_periph_clk_en;
  endproperty
  property p_idle_exit;
    s_idle_wake |=> s_vector_run;
  endproperty
  property p_idle_stay;
    MODE == PMCS_ST_IDLE && !IDLE_WAKE_IRQ |=> MODE == PMCS_ST_IDLE;
  endproperty
  property p_stop_exit;
    MODE == PMCS_ST_STOP |=> MODE inside {PMCS_ST_STOP, PMCS_ST_OSC_WAIT};
  endproperty
  property p_sleep_exit;
    MODE == PMCS_ST_SLEEP |=> MODE inside {PMCS_ST_SLEEP, PMCS_ST_REG_WAIT};
  endproperty
  property p_osc_first;
    MODE == PMCS_ST_OSC_WAIT |-> GATE.fast_osc_en && !GATE.cpu_clk_en && osc_cnt_ff < OSC_SETTLE_CYC;
  endproperty
  property p_wake_len;
    MODE == PMCS_ST_RUN && osc_cnt_ff != 9'h000 |-> osc_cnt_ff == OSC_SETTLE_CYC && osc_cnt_ff < 64;
  endproperty
  property p_entry_wait;
    MODE == PMCS_ST_RUN && !CPU_INSTR_DONE |=> MODE == PMCS_ST_RUN;
  endproperty
  property p_pulse_one;
    WAKE_VECTOR || WAKE_RESUME |=> !WAKE_VECTOR && !WAKE_RESUME;
  endproperty
  property p_upper_zero;
    SFR_ADDR == PMCS_ADDR_CLOCK_DIVIDER_MODE |=> !SFR_RDATA[7];
  endproperty

  a_sleep_off: assert property (p_sleep_off) else $error("sleep left a supply or clock on");
  a_stop_off: assert property (p_stop_off) else $error("stop left a clock running");
  a_idle_gate: assert property (p_idle_gate) else $error("idle gating wrong");
  a_idle_exit: assert property (p_idle_exit) else $error("idle wake did not vector");
  a_idle_stay: assert property (p_idle_stay) else $error("idle left without interrupt");
  a_stop_exit: assert property (p_stop_exit) else $error("stop left by wrong path");
  a_sleep_exit: assert property (p_sleep_exit) else $error("sleep left by wrong path");
  a_osc_first: assert property (p_osc_first) else $error("clock resumed before oscillator");
  a_wake_len: assert property (p_wake_len) else $error("oscillator restart length wrong");
  a_entry_wait: assert property (p_entry_wait) else $error("mode left run early");
  a_pulse_one: assert property (p_pulse_one) else $error("wake pulse too long");
  a_upper_zero: assert property (p_upper_zero) else $error("upper divider bit read as one");
endmodule

bind pmcs_top pmcs_top_asserts #(.OSC_SETTLE_CYC(OSC_SETTLE_CYC), .WAKE_LINES(WAKE_LINES)) u_chk (
  .CLK_SYS(CLK_SYS),
  .RESET_PIN_LOW(RESET_PIN_LOW),
  .SFR_ADDR(SFR_ADDR),
  .CPU_INSTR_DONE(CPU_INSTR_DONE),
  .IDLE_WAKE_IRQ(IDLE_WAKE_IRQ),
  .SFR_RDATA(SFR_RDATA),
  .GATE(GATE),
  .MODE(MODE),
  .WAKE_VECTOR(WAKE_VECTOR),
  .WAKE_RESUME(WAKE_RESUME)
);

//--- test/testbench.sv
// Self-checking bench for the power mode and clock select block
`timescale 1ns/1ps
module testbench;
  import pmcs_pkg::*;
  localparam int DIV = 4;
  logic CLK_SYS = 1'b0;
  logic RESET_PIN_LOW = 1'b0;
  logic [7:0] SFR_ADDR = 8'h00;
  logic SFR_WR = 1'b0;
  logic [7:0] SFR_WDATA = 8'h00;
  logic CPU_INSTR_DONE = 1'b0;
  logic TIMED_WINDOW_OPEN = 1'b0;
  logic SLOW_OSC_TICK;
  logic [7:0] WAKE_SRC = 8'h00;
  logic [7:0] WAKE_IRQ_EN = 8'h00;
  logic IDLE_WAKE_IRQ = 1'b0;
  logic [7:0] SFR_RDATA;
  pmcs_gate_type GATE;
  pmcs_clk_cfg_type CLK_CFG;
  pmcs_state_type MODE;
  logic WAKE_VECTOR;
  logic WAKE_RESUME;
  int errors = 0;
  int tests_run = 0;

  // Short oscillator settle keeps each wake quick
  pmcs_top #(.OSC_SETTLE_CYC(2), .WAKE_LINES(8)) uut (.CLK_SYS(CLK_SYS), .RESET_PIN_LOW(RESET_PIN_LOW), .SFR_ADDR(SFR_ADDR),
    .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .CPU_INSTR_DONE(CPU_INSTR_DONE),
    .TIMED_WINDOW_OPEN(TIMED_WINDOW_OPEN), .SLOW_OSC_TICK(SLOW_OSC_TICK), .WAKE_SRC(WAKE_SRC),
    .WAKE_IRQ_EN(WAKE_IRQ_EN), .IDLE_WAKE_IRQ(IDLE_WAKE_IRQ), .SFR_RDATA(SFR_RDATA), .GATE(GATE),
    .CLK_CFG(CLK_CFG), .MODE(MODE), .WAKE_VECTOR(WAKE_VECTOR), .WAKE_RESUME(WAKE_RESUME));
  pmcs_osc_model #(.DIV(DIV)) u_osc (.clk(CLK_SYS), .rst_n(RESET_PIN_LOW), .tick(SLOW_OSC_TICK));

  always #5 CLK_SYS = ~CLK_SYS;

  task give_verdict;
    $display("Comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task tick;
    @(posedge CLK_SYS);
    #1;
  endtask

  task chk(input string nm, input logic [8:0] exp, input logic [8:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    tick;
    SFR_ADDR = a;
    SFR_WDATA = d;
    SFR_WR = 1'b1;
    tick;
    SFR_WR = 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [7:0] e);
    tick;
    SFR_ADDR = a;
    tick;
    chk("rdata", {1'b0, e}, {1'b0, SFR_RDATA});
  endtask

  task done;
    tick;
    CPU_INSTR_DONE = 1'b1;
    tick;
    CPU_INSTR_DONE = 1'b0;
  endtask

  task wm(input pmcs_state_type m);
    int n;
    n = 0;
    while (MODE !== m && n < 2000)
    begin
      tick;
      n++;
    end
    chk("mode", 9'(m), 9'(MODE));
  endtask

  // A mode that must not change is checked once, after four cycles
  task stay(input pmcs_state_type m);
    repeat (4) tick;
    chk("mode", 9'(m), 9'(MODE));
  endtask

  function automatic logic [8:0] exp_div(input int c);
    if (c == 0)
      return 9'h001;
    if (c <= 8)
      return 9'(2 * c);
    if (c <= 11)
      return 9'(32 << (c - 9));
    return 9'h100;
  endfunction

  task t_reset;
    wm(PMCS_ST_RUN);
    rd(PMCS_ADDR_POWER_MODE_CONTROL, 8'h00);
    rd(PMCS_ADDR_SYSTEM_CLOCK_SELECT, 8'h90);
    chk("source", 9'h000, {7'h0, CLK_CFG.source});
    rd(PMCS_ADDR_WAKE_SOURCE_MASK, 8'hFF);
    rd(PMCS_ADDR_CLOCK_DIVIDER_MODE, 8'h40);
    rd(8'h55, 8'h00);
    chk("ratio", 9'h020, CLK_CFG.prediv_ratio);
  endtask

  task t_regs;
    int c;
    wr(PMCS_ADDR_SYSTEM_CLOCK_SELECT, 8'h00);
    rd(PMCS_ADDR_SYSTEM_CLOCK_SELECT, 8'h90);
    TIMED_WINDOW_OPEN = 1'b1;
    wr(PMCS_ADDR_CLOCK_DIVIDER_MODE, 8'hFF);
    rd(PMCS_ADDR_CLOCK_DIVIDER_MODE, 8'h60);
    wr(PMCS_ADDR_POWER_MODE_CONTROL, 8'h80);
    rd(PMCS_ADDR_POWER_MODE_CONTROL, 8'h80);
    chk("cfg", 9'h007, {6'h0, CLK_CFG.baud_double, CLK_CFG.full_speed, CLK_CFG.auto_return});
    for (c = 0; c < 16; c++)
    begin
      wr(PMCS_ADDR_SYSTEM_CLOCK_SELECT, {c[3:0], 2'h3, c[1:0]});
      rd(PMCS_ADDR_SYSTEM_CLOCK_SELECT, {c[3:0], 2'h0, c[1:0]});
      chk("ratio", exp_div(c), CLK_CFG.prediv_ratio);
      chk("source", {7'h0, c[1:0]}, {7'h0, CLK_CFG.source});
    end
    wr(PMCS_ADDR_SYSTEM_CLOCK_SELECT, 8'h33);
    wr(PMCS_ADDR_WAKE_SOURCE_MASK, 8'h01);
    TIMED_WINDOW_OPEN = 1'b0;
    wr(PMCS_ADDR_WAKE_SOURCE_MASK, 8'hFF);
    rd(PMCS_ADDR_WAKE_SOURCE_MASK, 8'h01);
  endtask

  task t_stop;
    wr(PMCS_ADDR_POWER_MODE_CONTROL, 8'h02);
    stay(PMCS_ST_RUN);
    done;
    wm(PMCS_ST_STOP);
    chk("gates", 9'h0, {5'h0, GATE.cpu_clk_en, GATE.integ_clk_en, GATE.ext_periph_clk_en, GATE.fast_osc_en});
    WAKE_SRC[1] = 1'b1;
    stay(PMCS_ST_STOP);
    WAKE_SRC[0] = 1'b1;
    wm(PMCS_ST_OSC_WAIT);
    chk("osc", 9'h1, {8'h0, GATE.fast_osc_en});
    wm(PMCS_ST_RUN);
    chk("pulses", 9'h2, {7'h0, WAKE_RESUME, WAKE_VECTOR});
    chk("ratio", 9'h006, CLK_CFG.prediv_ratio);
    done;
    stay(PMCS_ST_RUN);
  endtask

  task t_sleep;
    int n;
    WAKE_IRQ_EN = 8'hFF;
    wr(PMCS_ADDR_POWER_MODE_CONTROL, 8'h06);
    done;
    wm(PMCS_ST_SLEEP);
    chk("supply", 9'h0, {6'h0, GATE.main_reg_en, GATE.bandgap_en, GATE.cpu_clk_en});
    stay(PMCS_ST_SLEEP);
    WAKE_SRC = 8'h00;
    tick;
    WAKE_SRC[0] = 1'b1;
    wm(PMCS_ST_REG_WAIT);
    n = 0;
    while (MODE === PMCS_ST_REG_WAIT && n < 2000)
    begin
      tick;
      n++;
    end
    chk("regwait", 9'h1, {8'h0, n >= 7 * DIV && n <= 9 * DIV});
    wm(PMCS_ST_RUN);
    chk("pulses", 9'h1, {7'h0, WAKE_RESUME, WAKE_VECTOR});
    done;
    stay(PMCS_ST_RUN);
  endtask

  task t_idle;
    wr(PMCS_ADDR_POWER_MODE_CONTROL, 8'h01);
    done;
    wm(PMCS_ST_IDLE);
    chk("idle", 9'h3, {6'h0, GATE.cpu_clk_en, GATE.integ_rst, GATE.ext_periph_clk_en});
    stay(PMCS_ST_IDLE);
    IDLE_WAKE_IRQ = 1'b1;
    wm(PMCS_ST_RUN);
    chk("pulses", 9'h1, {7'h0, WAKE_RESUME, WAKE_VECTOR});
    IDLE_WAKE_IRQ = 1'b0;
    done;
    stay(PMCS_ST_RUN);
  endtask

  initial
  begin
    repeat (20) @(posedge CLK_SYS);
    #1;
    RESET_PIN_LOW = 1'b1;
    t_reset;
    t_regs;
    t_stop;
    t_sleep;
    t_idle;
    give_verdict;
  end

  // Whole run needs some 1300 cycles
  initial
  begin
    #200000;
    errors++;
    give_verdict;
  end
endmodule
